// file: include/spu_defines.vh
// Register indices, field positions, reset values and rate constants
// for the serial port block.
// Assumes a 12-bit APB byte address; byte address is four times the index.
`ifndef SPU_DEFINES_VH
`define SPU_DEFINES_VH
`define SPU_IDX_POWER_CONTROL_REG 10'h087
`define SPU_IDX_SERIAL_CONTROL_REG 10'h098
`define SPU_IDX_SBUF 10'h099
`define SPU_IDX_CFG 10'h09A
`define SPU_IDX_ADDR 10'h09B
`define SPU_IDX_STAT 10'h09C
`define SPU_RST_POWER_CONTROL_REG 8'h10
`define SPU_RST_CFG 3'h0
`define SPU_RST_ADDR 16'h0000
`define SPU_SC_RI 0
`define SPU_SC_TI 1
`define SPU_SC_RB8 2
`define SPU_SC_TB8 3
`define SPU_SC_REN 4
`define SPU_SC_SM2 5
`define SPU_SC_SM1 6
`define SPU_SC_B7 7
`define SPU_PC_DBL 7
`define SPU_PC_B7SEL 6
`define SPU_CFG_SIX 0
`define SPU_CFG_TXSRC 1
`define SPU_CFG_RXSRC 2
`define SPU_MODE0 2'h0
`define SPU_MODE1 2'h1
`define SPU_MODE2 2'h2
`define SPU_M0_DIV6 4'h6
`define SPU_M0_DIV12 4'hC
`define SPU_M2_PER_6_FAST 7'h10
`define SPU_M2_PER_6_SLOW 7'h20
`define SPU_M2_PER_12_FAST 7'h20
`define SPU_M2_PER_12_SLOW 7'h40
`define SPU_OVS_MID 4'h7
`define SPU_OVS_END 4'hF
`define SPU_STOP_8BIT 4'h9
`define SPU_STOP_9BIT 4'hA
`endif

// file: logic/spu_uart.v
// Serial port with APB register access and a transmit FIFO.
// Assumes clk_sys is the oscillator clock and timer overflow pulses
// are one-cycle strobes on clk_sys.
//
// What this block does
// - Two mode bits pick shift register, 8-bit UART or two 9-bit UARTs
// - Mode 0 shifts at clock divided by 6 or 12 per clock mode
// - Mode 2 bit rate is clock /32 or /16, or /64 or /32
// - Doubler bit governs baud rate in modes 1, 2 and 3
// - Bit-7 select maps control bit 7 to mode bit or framing error
// - Bad stop bit sets framing error, held until software clears it
// - Modes 2/3 with filter: done only on ninth bit 1 and address match
// - Mode 1 with filter: done only after a valid stop bit
// - Reception only while receive-allow bit is 1
// - Modes 2/3 send the software ninth bit as ninth data bit
// - Ninth bit holds received ninth, mode 1 stop bit with filter off, unused mode 0
// - Transmit done at end of 8th bit mode 0, else stop start
// - Receive done at end of 8th bit mode 0, else mid stop
// - Modes 1/3 clocks from timer 2 or timer 1 per source select
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "spu_defines.vh"

// ----------------------------------------
// Transmit FIFO
// ----------------------------------------
module spu_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_sys,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0] level
);
  localparam [AW:0] FULL = DEPTH[AW:0];
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] cnt_ff;
  wire push;
  wire pop;
  assign in_ready = (cnt_ff != FULL);
  assign out_valid = (cnt_ff != {(AW+1){1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr_ff];
  assign level = cnt_ff;
  always @(posedge clk_sys)
  begin
    if (push)
    begin
      mem[wr_ptr_ff] <= in_data;
    end
  end
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push & ~pop)
      begin
        cnt_ff <= cnt_ff + 1'b1;
      end
      else if (pop & ~push)
      begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule // spu_fifo

// ----------------------------------------
// Serial port top
// ----------------------------------------
module spu_uart (
  input wire clk_sys,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire timer1_ovf,
  input wire timer2_ovf,
  input wire rxd_in,
  output wire rxd_out,
  output wire rxd_oe_n,
  output wire txd_out
);
  localparam [2:0] SEL_NONE = 3'h0;
  localparam [2:0] SEL_POWER_CONTROL_REG = 3'h1;
  localparam [2:0] SEL_SERIAL_CONTROL_REG = 3'h2;
  localparam [2:0] SEL_SBUF = 3'h3;
  localparam [2:0] SEL_CFG = 3'h4;
  localparam [2:0] SEL_ADDR = 3'h5;
  localparam [2:0] SEL_STAT = 3'h6;
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_M0 = 2'h1;
  localparam [1:0] ST_UART = 2'h2;

  function [2:0] reg_dec;
    input [11:0] a;
    begin
      case (a[11:2])
        `SPU_IDX_POWER_CONTROL_REG: reg_dec = SEL_POWER_CONTROL_REG;
        `SPU_IDX_SERIAL_CONTROL_REG: reg_dec = SEL_SERIAL_CONTROL_REG;
        `SPU_IDX_SBUF: reg_dec = SEL_SBUF;
        `SPU_IDX_CFG: reg_dec = SEL_CFG;
        `SPU_IDX_ADDR: reg_dec = SEL_ADDR;
        `SPU_IDX_STAT: reg_dec = SEL_STAT;
        default: reg_dec = SEL_NONE;
      endcase
    end
  endfunction

  reg serial_mode_bit0_ff;
  reg serial_mode_bit1_ff;
  reg multiprocessor_filter_ff;
  reg ren_ff;
  reg tx_ninth_bit_ff;
  reg rx_ninth_bit_ff;
  reg transmit_done_flag_ff;
  reg receive_done_flag_ff;
  reg framing_error_flag_ff;
  reg [7:0] power_control_reg_ff;
  reg [2:0] cfg_ff;
  reg [15:0] addr_ff;
  reg [7:0] rbuf_ff;
  reg [31:0] prdata_ff;
  reg [3:0] m0_cnt_ff;
  reg m0clk_ff;
  reg [1:0] tx_st_ff;
  reg [10:0] tx_sh_ff;
  reg [3:0] tx_bit_ff;
  reg [3:0] tx_ovs_ff;
  reg tx_line_ff;
  reg rxd_out_ff;
  reg rxd_oe_n_ff;
  reg [1:0] rx_st_ff;
  reg [7:0] rx_sh_ff;
  reg rx_nine_ff;
  reg [3:0] rx_bit_ff;
  reg [3:0] rx_ovs_ff;
  reg rxs1_ff;
  reg rxs2_ff;
  reg rxs3_ff;
  reg set_ti_ff;
  reg set_ri_ff;
  reg set_fe_ff;
  reg load_rb_ff;
  reg [7:0] rbuf_in_ff;
  reg rb8_in_ff;
  reg upd_rb8_ff;

  wire [2:0] sel = reg_dec(paddr);
  wire [1:0] mode = {serial_mode_bit0_ff, serial_mode_bit1_ff};
  wire nine = serial_mode_bit0_ff;
  wire dbl = power_control_reg_ff[`SPU_PC_DBL];
  wire b7sel = power_control_reg_ff[`SPU_PC_B7SEL];
  wire six = cfg_ff[`SPU_CFG_SIX];
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [7:0] fifo_out_data;
  wire [4:0] fifo_level;
  wire fifo_in_valid = psel & penable & pwrite & (sel == SEL_SBUF);
  wire wr = psel & penable & pready & pwrite;
  wire [7:0] wd = pwdata[7:0];
  wire [1:0] ovs_tick;
  wire [3:0] stop_idx = nine ? `SPU_STOP_9BIT : `SPU_STOP_8BIT;

  assign pready = ~(fifo_in_valid & ~fifo_in_ready);
  assign pslverr = psel & penable & (sel == SEL_NONE);
  assign prdata = prdata_ff;
  assign rxd_out = rxd_out_ff;
  assign rxd_oe_n = rxd_oe_n_ff;
  assign txd_out = (mode == `SPU_MODE0) ? m0clk_ff : tx_line_ff;

  spu_fifo #(.WIDTH(8), .DEPTH(16), .AW(4)) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(wd),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      prdata_ff <= 32'h0000_0000;
    end
    else if (psel & ~penable & ~pwrite)
    begin
      case (sel)
        SEL_POWER_CONTROL_REG: prdata_ff <= {24'h00_0000, power_control_reg_ff};
        SEL_SERIAL_CONTROL_REG: prdata_ff <= {24'h00_0000,
          b7sel ? framing_error_flag_ff : serial_mode_bit0_ff,
          serial_mode_bit1_ff, multiprocessor_filter_ff, ren_ff,
          tx_ninth_bit_ff, rx_ninth_bit_ff,
          transmit_done_flag_ff, receive_done_flag_ff};
        SEL_SBUF: prdata_ff <= {24'h00_0000, rbuf_ff};
        SEL_CFG: prdata_ff <= {29'h0000_0000, cfg_ff};
        SEL_ADDR: prdata_ff <= {16'h0000, addr_ff};
        SEL_STAT: prdata_ff <= {25'h000_0000, rx_st_ff != ST_IDLE,
          tx_st_ff != ST_IDLE, fifo_level};
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      power_control_reg_ff <= `SPU_RST_POWER_CONTROL_REG;
      cfg_ff <= `SPU_RST_CFG;
      addr_ff <= `SPU_RST_ADDR;
      serial_mode_bit0_ff <= 1'b0;
      serial_mode_bit1_ff <= 1'b0;
      multiprocessor_filter_ff <= 1'b0;
      ren_ff <= 1'b0;
      tx_ninth_bit_ff <= 1'b0;
    end
    else if (wr)
    begin
      if (sel == SEL_POWER_CONTROL_REG)
        power_control_reg_ff <= wd;
      if (sel == SEL_CFG)
        cfg_ff <= wd[2:0];
      if (sel == SEL_ADDR)
        addr_ff <= pwdata[15:0];
      if (sel == SEL_SERIAL_CONTROL_REG)
      begin
        if (~b7sel)
          serial_mode_bit0_ff <= wd[`SPU_SC_B7];
        serial_mode_bit1_ff <= wd[`SPU_SC_SM1];
        multiprocessor_filter_ff <= wd[`SPU_SC_SM2];
        ren_ff <= wd[`SPU_SC_REN];
        tx_ninth_bit_ff <= wd[`SPU_SC_TB8];
      end
    end
  end

  // Hardware set wins over a software write in the same cycle
  wire wr_sc = wr & (sel == SEL_SERIAL_CONTROL_REG);
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      transmit_done_flag_ff <= 1'b0;
      receive_done_flag_ff <= 1'b0;
      framing_error_flag_ff <= 1'b0;
      rx_ninth_bit_ff <= 1'b0;
      rbuf_ff <= 8'h00;
    end
    else
    begin
      if (set_ti_ff)
        transmit_done_flag_ff <= 1'b1;
      else if (wr_sc)
        transmit_done_flag_ff <= wd[`SPU_SC_TI];
      if (set_ri_ff)
        receive_done_flag_ff <= 1'b1;
      else if (wr_sc)
        receive_done_flag_ff <= wd[`SPU_SC_RI];
      if (set_fe_ff)
        framing_error_flag_ff <= 1'b1;
      else if (wr_sc & b7sel)
        framing_error_flag_ff <= wd[`SPU_SC_B7];
      if (upd_rb8_ff)
        rx_ninth_bit_ff <= rb8_in_ff;
      else if (wr_sc)
        rx_ninth_bit_ff <= wd[`SPU_SC_RB8];
      if (load_rb_ff)
        rbuf_ff <= rbuf_in_ff;
    end
  end

  // ----------------------------------------
  // Bit rate generation
  // ----------------------------------------
  wire [3:0] m0_div = six ? `SPU_M0_DIV6 : `SPU_M0_DIV12;
  wire m0_end = (m0_cnt_ff == m0_div - 4'h1);
  wire m0_mid = (m0_cnt_ff == (m0_div >> 1) - 4'h1);
  wire [6:0] m2_per = six ? (dbl ? `SPU_M2_PER_6_FAST : `SPU_M2_PER_6_SLOW) :
    (dbl ? `SPU_M2_PER_12_FAST : `SPU_M2_PER_12_SLOW);
  wire [2:0] m2_lim = m2_per[6:4] - 3'h1;
  wire m0_rx_go = ren_ff & ~receive_done_flag_ff & (rx_st_ff == ST_IDLE) & (tx_st_ff == ST_IDLE) &
    ~fifo_out_valid & m0_end;
  wire m0_more = (tx_st_ff == ST_M0) ? (tx_bit_ff != 4'h7) : ((rx_st_ff == ST_M0) & (rx_bit_ff != 4'h7));
  wire m0_start = (mode == `SPU_MODE0) & ((fifo_out_valid & fifo_out_ready) | m0_rx_go);

  always @(posedge clk_sys)
  begin
    if (rst | m0_end)
      m0_cnt_ff <= 4'h0;
    else
      m0_cnt_ff <= m0_cnt_ff + 4'h1;
  end

  // Shift clock: low in first half of each bit, high in second
  always @(posedge clk_sys)
  begin
    if (rst)
      m0clk_ff <= 1'b1;
    else if (m0_mid)
      m0clk_ff <= 1'b1;
    else if (m0_end)
      m0clk_ff <= ~(m0_more | m0_start);
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_div
      reg [2:0] div_ff;
      wire src = (g == 0) ? cfg_ff[`SPU_CFG_TXSRC] : cfg_ff[`SPU_CFG_RXSRC];
      wire ovf = src ? timer2_ovf : timer1_ovf;
      wire pulse = (mode == `SPU_MODE2) ? 1'b1 : ovf;
      wire [2:0] lim = (mode == `SPU_MODE2) ? m2_lim : (dbl ? 3'h0 : 3'h1);
      assign ovs_tick[g] = pulse & (div_ff == lim);
      always @(posedge clk_sys)
      begin
        if (rst | ovs_tick[g])
          div_ff <= 3'h0;
        else if (pulse)
          div_ff <= div_ff + 3'h1;
      end
    end
  endgenerate

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  wire tx_go = (mode == `SPU_MODE0) ? (rx_st_ff == ST_IDLE) & m0_end : ovs_tick[0];
  assign fifo_out_ready = (tx_st_ff == ST_IDLE) & tx_go;

  always @(posedge clk_sys)
  begin
    set_ti_ff <= 1'b0;
    if (rst)
    begin
      tx_st_ff <= ST_IDLE;
      tx_sh_ff <= 11'h7FF;
      tx_bit_ff <= 4'h0;
      tx_ovs_ff <= 4'h0;
      tx_line_ff <= 1'b1;
      rxd_out_ff <= 1'b1;
      rxd_oe_n_ff <= 1'b1;
    end
    else
    begin
      case (tx_st_ff)
        ST_IDLE:
        begin
          tx_line_ff <= 1'b1;
          if (fifo_out_valid & fifo_out_ready)
          begin
            tx_bit_ff <= 4'h0;
            tx_ovs_ff <= 4'h0;
            if (mode == `SPU_MODE0)
            begin
              tx_sh_ff <= {3'h7, fifo_out_data};
              rxd_out_ff <= fifo_out_data[0];
              rxd_oe_n_ff <= 1'b0;
              tx_st_ff <= ST_M0;
            end
            else
            begin
              tx_sh_ff <= {1'b1, nine ? tx_ninth_bit_ff : 1'b1, fifo_out_data, 1'b0};
              tx_line_ff <= 1'b0;
              tx_st_ff <= ST_UART;
            end
          end
        end
        ST_M0:
        begin
          if (m0_end)
          begin
            if (tx_bit_ff == 4'h7)
            begin
              set_ti_ff <= 1'b1;
              rxd_oe_n_ff <= 1'b1;
              rxd_out_ff <= 1'b1;
              tx_st_ff <= ST_IDLE;
            end
            else
            begin
              tx_bit_ff <= tx_bit_ff + 4'h1;
              tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
              rxd_out_ff <= tx_sh_ff[1];
            end
          end
        end
        ST_UART:
        begin
          if (ovs_tick[0])
          begin
            tx_ovs_ff <= tx_ovs_ff + 4'h1;
            if (tx_ovs_ff == `SPU_OVS_END)
            begin
              if (tx_bit_ff == stop_idx)
              begin
                tx_st_ff <= ST_IDLE;
              end
              else
              begin
                if (tx_bit_ff + 4'h1 == stop_idx)
                  set_ti_ff <= 1'b1;
                tx_bit_ff <= tx_bit_ff + 4'h1;
                tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
                tx_line_ff <= tx_sh_ff[1];
              end
            end
          end
        end
        default: tx_st_ff <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      rxs1_ff <= 1'b1;
      rxs2_ff <= 1'b1;
      rxs3_ff <= 1'b1;
    end
    else
    begin
      rxs1_ff <= rxd_in;
      rxs2_ff <= rxs1_ff;
      rxs3_ff <= rxs2_ff;
    end
  end

  wire addr_hit = (((rx_sh_ff ^ addr_ff[7:0]) & addr_ff[15:8]) == 8'h00) |
    (((rx_sh_ff ^ 8'hFF) & (addr_ff[7:0] | addr_ff[15:8])) == 8'h00);
  wire rx_mid = ovs_tick[1] & (rx_ovs_ff == `SPU_OVS_MID);
  wire accept = (mode == `SPU_MODE1) ? (~multiprocessor_filter_ff | rxs2_ff) :
    (~multiprocessor_filter_ff | (rx_nine_ff & addr_hit));

  always @(posedge clk_sys)
  begin
    set_ri_ff <= 1'b0;
    set_fe_ff <= 1'b0;
    load_rb_ff <= 1'b0;
    upd_rb8_ff <= 1'b0;
    rbuf_in_ff <= rx_sh_ff;
    rb8_in_ff <= nine ? rx_nine_ff : rxs2_ff;
    if (rst)
    begin
      rx_st_ff <= ST_IDLE;
      rx_sh_ff <= 8'h00;
      rx_nine_ff <= 1'b0;
      rx_bit_ff <= 4'h0;
      rx_ovs_ff <= 4'h0;
    end
    else if (~ren_ff)
      rx_st_ff <= ST_IDLE;
    else
    begin
      case (rx_st_ff)
        ST_IDLE:
        begin
          rx_bit_ff <= 4'h0;
          rx_ovs_ff <= 4'h0;
          if (mode == `SPU_MODE0)
          begin
            if (m0_rx_go)
              rx_st_ff <= ST_M0;
          end
          else if (rxs3_ff & ~rxs2_ff)
            rx_st_ff <= ST_UART;
        end
        ST_M0:
        begin
          if (m0_mid)
            rx_sh_ff <= {rxs2_ff, rx_sh_ff[7:1]};
          if (m0_end)
          begin
            rx_bit_ff <= rx_bit_ff + 4'h1;
            if (rx_bit_ff == 4'h7)
            begin
              set_ri_ff <= 1'b1;
              load_rb_ff <= 1'b1;
              rx_st_ff <= ST_IDLE;
            end
          end
        end
        ST_UART:
        begin
          if (ovs_tick[1])
            rx_ovs_ff <= rx_ovs_ff + 4'h1;
          if (ovs_tick[1] & (rx_ovs_ff == `SPU_OVS_END))
            rx_bit_ff <= rx_bit_ff + 4'h1;
          if (rx_mid)
          begin
            if (rx_bit_ff == 4'h0)
            begin
              if (rxs2_ff)
                rx_st_ff <= ST_IDLE;
            end
            else if (rx_bit_ff == stop_idx)
            begin
              rx_st_ff <= ST_IDLE;
              set_fe_ff <= ~rxs2_ff;
              if (accept)
              begin
                set_ri_ff <= 1'b1;
                load_rb_ff <= 1'b1;
                upd_rb8_ff <= nine | ~multiprocessor_filter_ff;
              end
            end
            else if (rx_bit_ff == 4'h9)
              rx_nine_ff <= rxs2_ff;
            else
              rx_sh_ff <= {rxs2_ff, rx_sh_ff[7:1]};
          end
        end
        default: rx_st_ff <= ST_IDLE;
      endcase
    end
  end
endmodule // spu_uart

// file: verif/spu_uart_props.sv
// Checker for the serial port top ports.
// Assumes spu_defines.vh on the include path; bound to spu_uart below.
`timescale 1ns/1ps
`include "spu_defines.vh"
module spu_uart_chk (
  input wire clk_sys,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire rxd_oe_n,
  input wire txd_out
);
  // ----------------------------------------
  // Shadow of mode and clock setting
  // ----------------------------------------
  wire acc = psel && penable;
  wire [9:0] idx = paddr[11:2];
  wire wt = acc && pready && pwrite;
  wire map = idx == `SPU_IDX_POWER_CONTROL_REG || (idx >= `SPU_IDX_SERIAL_CONTROL_REG && idx <= `SPU_IDX_STAT);
  reg [1:0] mode_ff;
  reg six_ff;
  reg sel_ff;
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      mode_ff <= 2'h0;
      six_ff <= 1'b0;
      sel_ff <= 1'b0;
    end
    else if (wt && idx == `SPU_IDX_POWER_CONTROL_REG)
      sel_ff <= pwdata[6];
    else if (wt && idx == `SPU_IDX_CFG)
      six_ff <= pwdata[0];
    else if (wt && idx == `SPU_IDX_SERIAL_CONTROL_REG)
    begin
      mode_ff[1] <= sel_ff ? mode_ff[1] : pwdata[7];
      mode_ff[0] <= pwdata[6];
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_RST_IDLE:
    assert property ($fell(rst) |-> txd_out && rxd_oe_n) else $error("outputs not idle after reset");
  AST_PREADY:
    assert property (acc && !(pwrite && idx == `SPU_IDX_SBUF) |-> pready) else $error("pready low");
  AST_SLVERR:
    assert property (acc |-> pslverr == !map) else $error("pslverr wrong for address");
  AST_NO_ERR:
    assert property (!acc |-> !pslverr) else $error("pslverr outside access");
  AST_RD_ZERO:
    assert property (acc && !pwrite && !map |-> prdata == 32'h0000_0000) else $error("unmapped read not 0");
  AST_OE:
    assert property ($stable(mode_ff) && mode_ff != `SPU_MODE0 |-> rxd_oe_n) else $error("data pin driven");
  AST_M2_BIT:
    assert property (mode_ff == `SPU_MODE2 && $fell(txd_out) |-> !txd_out [*8] ##1 !txd_out [*8])
      else $error("mode 2 start bit short");
  AST_M0_SIX:
    assert property (mode_ff == `SPU_MODE0 && six_ff && $fell(txd_out) |-> !txd_out [*3] ##1 txd_out [*3])
      else $error("mode 0 clock not 6");
  AST_M0_TWELVE:
    assert property (mode_ff == `SPU_MODE0 && !six_ff && $fell(txd_out) |-> !txd_out [*6] ##1 txd_out [*6])
      else $error("mode 0 clock not 12");
endmodule // spu_uart_chk

bind spu_uart spu_uart_chk i_chk (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rxd_oe_n(rxd_oe_n), .txd_out(txd_out));

// file: verif/spu_far_model.sv
// Far-side serial device: sends and receives frames.
// Assumes the bench gives the bit period in clk_sys cycles.
`timescale 1ns/1ps
module spu_far_model (
  input wire clk_sys,
  input wire txd_out,
  output reg rxd
);
  initial rxd = 1'b1;
  // ----------------------------------------
  // Send: start low, data LSB first, idle high
  // ----------------------------------------
  task send(input [7:0] d, input b9, input stop, input integer per, input nine);
    integer i;
    reg [10:0] f;
    begin
      f = nine ? {stop, b9, d, 1'b0} : {1'b1, stop, d, 1'b0};
      for (i = 0; i < 11; i = i + 1)
      begin
        rxd <= f[i];
        repeat (per) @(posedge clk_sys);
      end
      rxd <= 1'b1;
    end
  endtask
  // ----------------------------------------
  // Receive: sample each bit at its middle
  // ----------------------------------------
  task recv(output [7:0] d, output b9, output stop, input integer per);
    integer i;
    reg [10:0] f;
    begin
      @(negedge txd_out);
      repeat (per / 2) @(posedge clk_sys);
      for (i = 0; i < 11; i = i + 1)
      begin
        f[i] = txd_out;
        if (i < 10)
          repeat (per) @(posedge clk_sys);
      end
      {stop, b9, d} = f[10:1];
    end
  endtask
endmodule // spu_far_model

// file: verif/tb_spu_uart.sv
// Self-checking bench for the serial port.
// Assumes spu_defines.vh on the include path and a far-side model.
`timescale 1ns/1ps
`include "spu_defines.vh"
module tb_spu_uart;
  localparam [9:0] ix_pc = `SPU_IDX_POWER_CONTROL_REG;
  localparam [9:0] ix_sc = `SPU_IDX_SERIAL_CONTROL_REG;
  localparam [9:0] ix_sb = `SPU_IDX_SBUF;
  localparam [9:0] ix_cf = `SPU_IDX_CFG;
  localparam [9:0] ix_st = `SPU_IDX_STAT;
  reg clk_sys;
  reg rst;
  reg psel;
  reg penable;
  reg pwrite;
  reg [11:0] paddr;
  reg [31:0] pwdata;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  reg timer1_ovf = 1'b0;
  reg timer2_ovf = 1'b0;
  reg [1:0] tcnt = 2'h0;
  wire far_rxd;
  wire rxd_out;
  wire rxd_oe_n;
  wire txd_out;
  wire rxd_in = rxd_oe_n ? far_rxd : rxd_out;
  reg [31:0] rdv;
  reg erv;
  reg [7:0] rd8;
  reg r9;
  reg rs;
  integer error_cnt = 0;
  integer n_compared = 0;
  integer waits = 0;
  integer cyc = 0;
  integer k;
  spu_uart i_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer1_ovf(timer1_ovf), .timer2_ovf(timer2_ovf), .rxd_in(rxd_in), .rxd_out(rxd_out),
    .rxd_oe_n(rxd_oe_n), .txd_out(txd_out));
  spu_far_model i_far (.clk_sys(clk_sys), .txd_out(txd_out), .rxd(far_rxd));
  // ----------------------------------------
  // Clock, timers, watchdog
  // ----------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    tcnt <= tcnt + 2'h1;
    timer1_ovf <= tcnt == 2'h3;
    timer2_ovf <= tcnt[0];
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      error_cnt = error_cnt + 1;
      report_and_stop;
    end
  end
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task apb(input wr, input [9:0] ix, input [31:0] wd);
    begin
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {ix, 2'b00};
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1)
      begin
        waits = waits + 1;
        @(posedge clk_sys);
      end
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task ck(input ok);
    begin
      n_compared = n_compared + 1;
      if (ok !== 1'b1)
      begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0t result mismatch", $time);
      end
    end
  endtask
  task chk(input [9:0] ix, input [31:0] m, input [31:0] e);
    begin
      apb(1'b0, ix, 32'h0000_0000);
      n_compared = n_compared + 1;
      if ((rdv & m) !== e)
      begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0t reg %h read %h exp %h", $time, ix, rdv, e);
      end
    end
  endtask
  task drain;
    begin
      apb(1'b0, ix_st, 32'h0000_0000);
      for (k = 0; k < 3000 && (rdv & 32'h0000_003F) !== 32'h0000_0000; k = k + 1)
        apb(1'b0, ix_st, 32'h0000_0000);
      chk(ix_st, 32'h0000_003F, 32'h0000_0000);
    end
  endtask
  task txf(input [7:0] sc, input [7:0] pc, input [7:0] cf, input integer per, input [7:0] d);
    begin
      apb(1'b1, ix_cf, cf);
      apb(1'b1, ix_pc, pc);
      apb(1'b1, ix_sc, sc);
      fork
        i_far.recv(rd8, r9, rs, per);
        apb(1'b1, ix_sb, d);
      join
      ck(rd8 === d && r9 === sc[3] && rs === 1'b1);
      chk(ix_sc, 32'h0000_0002, 32'h0000_0002);
      apb(1'b1, ix_sc, sc);
    end
  endtask
  task rxf(input [7:0] sc, input [7:0] d, input b9, input st, input integer per, input nine,
    input [7:0] m, input [7:0] e);
    begin
      apb(1'b1, ix_sc, sc);
      i_far.send(d, b9, st, per, nine);
      chk(ix_sc, m, e);
      apb(1'b1, ix_sc, sc);
    end
  endtask
  task report_and_stop;
    begin
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    rst = 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    chk(ix_pc, 32'hFFFF_FFFF, 32'h0000_0010);
    chk(ix_sc, 32'hFFFF_FFFF, 32'h0000_0000);
    apb(1'b0, 10'h010, 32'h0000_0000);
    ck(erv === 1'b1 && rdv === 32'h0000_0000);
    for (k = 0; k < 4; k = k + 1)
    begin
      apb(1'b1, ix_sc, k << 6);
      chk(ix_sc, 32'h0000_00FF, k << 6);
    end
    apb(1'b1, ix_pc, 32'h0000_0040);
    chk(ix_sc, 32'h0000_00FF, 32'h0000_0040);
    txf(8'h88, 8'h80, 8'h01, 16, 8'hA5);
    txf(8'h80, 8'h00, 8'h00, 64, 8'h5A);
    txf(8'hC8, 8'h80, 8'h03, 32, 8'hC3);
    apb(1'b1, ix_cf, 32'h0000_0001);
    apb(1'b1, `SPU_IDX_ADDR, 32'h0000_FF55);
    rxf(8'h90, 8'h3C, 1'b1, 1'b1, 16, 1'b1, 8'h07, 8'h05);
    chk(ix_sb, 32'h0000_00FF, 32'h0000_003C);
    rxf(8'h80, 8'h3C, 1'b1, 1'b1, 16, 1'b1, 8'h01, 8'h00);
    rxf(8'hB0, 8'h55, 1'b0, 1'b1, 16, 1'b1, 8'h01, 8'h00);
    rxf(8'hB0, 8'h12, 1'b1, 1'b1, 16, 1'b1, 8'h01, 8'h00);
    rxf(8'hB0, 8'h55, 1'b1, 1'b1, 16, 1'b1, 8'h01, 8'h01);
    rxf(8'hB0, 8'hFF, 1'b1, 1'b1, 16, 1'b1, 8'h01, 8'h01);
    rxf(8'h70, 8'h33, 1'b0, 1'b0, 64, 1'b0, 8'h01, 8'h00);
    rxf(8'h70, 8'h33, 1'b0, 1'b1, 64, 1'b0, 8'h01, 8'h01);
    rxf(8'h50, 8'h44, 1'b0, 1'b1, 64, 1'b0, 8'h05, 8'h05);
    apb(1'b1, ix_sc, 32'h0000_0090);
    apb(1'b1, ix_pc, 32'h0000_00C0);
    rxf(8'h10, 8'h11, 1'b0, 1'b0, 16, 1'b1, 8'h80, 8'h80);
    chk(ix_sc, 32'h0000_0080, 32'h0000_0000);
    apb(1'b1, ix_pc, 32'h0000_0000);
    apb(1'b1, ix_sc, 32'h0000_0000);
    waits = 0;
    for (k = 0; k < 20; k = k + 1)
      apb(1'b1, ix_sb, k);
    ck(waits > 0);
    drain;
    chk(ix_sc, 32'h0000_0002, 32'h0000_0002);
    apb(1'b1, ix_sc, 32'h0000_0000);
    apb(1'b1, ix_cf, 32'h0000_0000);
    r9 = 1'b1;
    fork
      for (k = 0; k < 8; k = k + 1)
      begin
        @(posedge txd_out);
        rd8 = {rxd_out, rd8[7:1]};
        r9 = r9 & (rxd_oe_n === 1'b0);
      end
      apb(1'b1, ix_sb, 32'h0000_0096);
    join
    ck(rd8 === 8'h96 && r9 === 1'b1);
    drain;
    chk(ix_sc, 32'h0000_0002, 32'h0000_0002);
    report_and_stop;
  end
endmodule // tb_spu_uart
